// [design/ata_host_map.vh]
// Register offsets, field positions and reset values of the drive host port
`ifndef ATA_HOST_MAP_VH
`define ATA_HOST_MAP_VH
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_IRQ_EN 8'h08
`define OFF_PIO_TIM 8'h0C
`define OFF_MDMA_TIM 8'h10
`define OFF_UDMA_TIM 8'h14
`define OFF_DMA_BASE 8'h18
`define OFF_DMA_LEN 8'h1C
`define OFF_CTRL2 8'h20
`define OFF_PIN_LVL 8'h24
`define OFF_BYTE_ORD 8'h28
`define OFF_PIO_RESULT 8'h2C
`define TASK_WIN_LO 8'h40
`define TASK_WIN_HI 8'h7C
`define CTRL_DMA_START 0
`define CTRL_DMA_OUT 1
`define CTRL_ULTRA 2
`define CTRL_SLAVE 3
`define CTRL_DRV_RESET 4
`define CTRL2_INTERFACE_ENABLE_BIT 0
`define STAT_DONE 0
`define STAT_INTRQ 1
`define STAT_RUN 2
`define STAT_PIO_BUSY 3
`define TIM_ACT_LSB 0
`define TIM_REC_LSB 8
`define TIM_SLAVE_LSB 16
`define TIM_RST 32'h0000_0000
`define STAT_WIDTH 4
`endif

// [design/ata_fifo_ram.v]
// Small two-port word store for the transfer FIFO, registered read data
`timescale 1ns/100ps
module ata_fifo_ram #(
    parameter AW = 4,
    parameter DW = 16
) (
    input wire ref_clk_i,
    input wire wr_en_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [DW-1:0] wr_data_i,
    input wire [AW-1:0] rd_addr_i,
    output reg [DW-1:0] rd_data_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule // ata_fifo_ram

// [design/ata_host.v]
// Host port for one ATA/ATAPI channel: task file window, PIO and DMA engine
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "ata_host_map.vh"
// Notes on behaviour
// - Drive interrupt is taken as a level, never as an edge.
// - Data register carries 16 bits; other task registers carry 8 bits.
// - All control and status bits are active high.
// - Each interrupt enable bit gates its matching status bit.
// - Timing fields count cycles of the bus clock.
// - Master and slave timing sets; the selected drive's set applies.
// - DMA base address register never changes; progress kept elsewhere.
// - Memory side of each DMA targets SDRAM addresses.
// - DMA length register never changes; remaining count kept elsewhere.
// - FIFO sustains multiword and ultra DMA data rates.
// - Task window access becomes a drive cycle on chip selects and addresses.
// - PIO modes 0-4, multiword DMA 0-2, ultra DMA 0-2 supported.
// - DMA data uses the memory bus; PIO uses the register port.
// - DMA needs no CPU; the CPU performs each PIO access.
// - Direction low while sending data to the drive, otherwise high.
// - Direction also low while sending the CRC word after ultra data-in.
// - One primary channel with a master and a slave drive.
module ata_host #(
    parameter FIFO_AW = 4,
    parameter [31:0] SDRAM_BASE = 32'h0000_0000,
    parameter [31:0] SDRAM_MASK = 32'h00FF_FFFF,
    parameter [15:0] CRC_SEED = 16'hFFFF
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output reg [31:0] reg_rdata_o,
    output wire irq_o,
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [31:0] mem_addr_o,
    output reg [15:0] mem_wdata_o,
    input wire [15:0] mem_rdata_i,
    input wire mem_ack_i,
    input wire [15:0] drive_data_i,
    output reg [15:0] drive_data_o,
    output reg drive_data_oe_n_o,
    output reg drive_select_lo_n_o,
    output reg drive_select_hi_n_o,
    output reg [2:0] drive_reg_addr_o,
    output reg dior_n_o,
    output reg diow_n_o,
    output reg dmack_n_o,
    output reg direction_o,
    output reg drive_reset_n_o,
    input wire iordy_i,
    input wire intrq_i,
    input wire dmarq_i
);
    localparam [4:0] D_IDLE = 5'h01;
    localparam [4:0] D_ASSERT = 5'h02;
    localparam [4:0] D_ACTIVE = 5'h04;
    localparam [4:0] D_RECOV = 5'h08;
    localparam [4:0] D_WAIT = 5'h10;

    function [15:0] swap16;
        input [15:0] w;
        input en;
        begin
            swap16 = en ? {w[7:0], w[15:8]} : w;
        end
    endfunction

    function [15:0] pick_time;
        input [31:0] tim;
        input slave;
        begin
            pick_time = slave ? tim[`TIM_SLAVE_LSB+15:`TIM_SLAVE_LSB] : tim[15:0];
        end
    endfunction

    function [15:0] crc_step;
        input [15:0] crc;
        input [15:0] w;
        integer i;
        reg [15:0] c;
        begin
            c = crc;
            for (i = 15; i >= 0; i = i - 1) begin
                c = (c[15] ^ w[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
            end
            crc_step = c;
        end
    endfunction

    // Pins pass four flops; stages two and three must agree
    reg [2:0] sync1;
    reg [2:0] sync2;
    reg [2:0] sync3;
    reg [2:0] pin_f;
    wire intrq_f = pin_f[0];
    wire iordy_f = pin_f[1];
    wire dmarq_f = pin_f[2];

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            pin_f <= 3'h0;
        end else begin
            sync1 <= {dmarq_i, iordy_i, intrq_i};
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) begin
                pin_f <= sync3;
            end
        end
    end

    reg [31:0] ctrl;
    reg [31:0] ctrl2;
    reg [`STAT_WIDTH-1:0] irq_en;
    reg [31:0] pio_tim;
    reg [31:0] mdma_tim;
    reg [31:0] udma_tim;
    reg [31:0] dma_base;
    reg [31:0] dma_len;
    reg byte_ord;
    reg [15:0] pio_result;
    reg done_flag;
    reg dma_run;
    reg dma_out;
    reg dma_ultra;
    reg [30:0] words_left;
    reg [15:0] crc;
    reg crc_pend;
    reg pio_pend;
    reg pio_wr;
    reg [3:0] pio_idx;
    reg [15:0] pio_wdata;
    reg [4:0] dstate;
    reg [7:0] cnt;
    reg cyc_dma;
    reg cyc_wr;
    reg [7:0] cyc_rec;
    reg [30:0] fetch_left;
    reg [31:0] addr_cnt;
    reg mem_gap;
    reg fifo_settled;
    reg [FIFO_AW:0] wr_ptr;
    reg [FIFO_AW:0] rd_ptr;
    wire [15:0] ram_q;

    wire if_en = ctrl2[`CTRL2_INTERFACE_ENABLE_BIT];
    wire slave = ctrl[`CTRL_SLAVE];
    wire fifo_empty = (wr_ptr == rd_ptr);
    wire fifo_avail = !fifo_empty && fifo_settled;
    wire fifo_full = (wr_ptr[FIFO_AW] != rd_ptr[FIFO_AW]) &&
        (wr_ptr[FIFO_AW-1:0] == rd_ptr[FIFO_AW-1:0]);
    wire in_window = (reg_addr_i >= `TASK_WIN_LO) && (reg_addr_i <= `TASK_WIN_HI);
    wire [15:0] t_pio = pick_time(pio_tim, slave);
    wire [15:0] t_dma = dma_ultra ? pick_time(udma_tim, slave) : pick_time(mdma_tim, slave);
    wire [`STAT_WIDTH-1:0] status = {pio_pend, dma_run, intrq_f, done_flag};
    wire dma_ready = dma_run && dmarq_f && (words_left != 31'h0) &&
        (dma_out ? fifo_avail : !fifo_full);
    wire crc_ready = dma_run && dmarq_f && crc_pend && (words_left == 31'h0);
    wire dma_finish = dma_run && (words_left == 31'h0) && !crc_pend &&
        (dma_out || (fifo_empty && !mem_req_o));
    wire drv_capture = (dstate == D_ACTIVE) && (cnt == 8'h00) && (cyc_dma || iordy_f);
    wire push = dma_out ? (mem_req_o && mem_ack_i) : (drv_capture && cyc_dma && !cyc_wr);
    wire pop = dma_out ? (drv_capture && cyc_dma && cyc_wr && !crc_pend) :
        (mem_req_o && mem_ack_i);
    wire [15:0] push_data = dma_out ? swap16(mem_rdata_i, byte_ord) : drive_data_i;

    assign irq_o = |(status & irq_en);

    ata_fifo_ram #(
        .AW(FIFO_AW),
        .DW(16)
    ) u_ram (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(push),
        .wr_addr_i(wr_ptr[FIFO_AW-1:0]),
        .wr_data_i(push_data),
        .rd_addr_i(rd_ptr[FIFO_AW-1:0]),
        .rd_data_o(ram_q)
    );

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= {(FIFO_AW+1){1'b0}};
            rd_ptr <= {(FIFO_AW+1){1'b0}};
            fifo_settled <= 1'b0;
        end else if (!dma_run) begin
            wr_ptr <= {(FIFO_AW+1){1'b0}};
            rd_ptr <= {(FIFO_AW+1){1'b0}};
            fifo_settled <= 1'b0;
        end else begin
            fifo_settled <= !fifo_empty;
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Memory side; a gap after each ack lets the FIFO read settle
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 32'h0;
            mem_wdata_o <= 16'h0;
            fetch_left <= 31'h0;
            addr_cnt <= 32'h0;
            mem_gap <= 1'b0;
        end else if (reg_we_i && (reg_addr_i == `OFF_CTRL) && !dma_run &&
            reg_wdata_i[`CTRL_DMA_START] && if_en) begin
            addr_cnt <= dma_base;
            fetch_left <= dma_len[31:1];
            mem_req_o <= 1'b0;
            mem_gap <= 1'b0;
        end else begin
            mem_gap <= 1'b0;
            if (mem_req_o) begin
                if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    mem_gap <= 1'b1;
                    addr_cnt <= addr_cnt + 32'h2;
                end
            end else if (dma_run && !mem_gap) begin
                if (dma_out && !fifo_full && (fetch_left != 31'h0)) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b0;
                    mem_addr_o <= SDRAM_BASE | (addr_cnt & SDRAM_MASK);
                    fetch_left <= fetch_left - 31'h1;
                end else if (!dma_out && fifo_avail) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_addr_o <= SDRAM_BASE | (addr_cnt & SDRAM_MASK);
                    mem_wdata_o <= swap16(ram_q, byte_ord);
                end
            end
        end
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0;
            ctrl <= 32'h0;
            ctrl2 <= 32'h0;
            irq_en <= {`STAT_WIDTH{1'b0}};
            pio_tim <= `TIM_RST;
            mdma_tim <= `TIM_RST;
            udma_tim <= `TIM_RST;
            dma_base <= 32'h0;
            dma_len <= 32'h0;
            byte_ord <= 1'b0;
            pio_result <= 16'h0;
            done_flag <= 1'b0;
            dma_run <= 1'b0;
            dma_out <= 1'b0;
            dma_ultra <= 1'b0;
            words_left <= 31'h0;
            crc <= 16'h0000;
            crc_pend <= 1'b0;
            pio_pend <= 1'b0;
            pio_wr <= 1'b0;
            pio_idx <= 4'h0;
            pio_wdata <= 16'h0000;
            dstate <= D_IDLE;
            cnt <= 8'h00;
            cyc_dma <= 1'b0;
            cyc_wr <= 1'b0;
            cyc_rec <= 8'h00;
            drive_data_o <= 16'h0000;
            drive_data_oe_n_o <= 1'b1;
            drive_select_lo_n_o <= 1'b1;
            drive_select_hi_n_o <= 1'b1;
            drive_reg_addr_o <= 3'h0;
            dior_n_o <= 1'b1;
            diow_n_o <= 1'b1;
            dmack_n_o <= 1'b1;
            direction_o <= 1'b1;
            drive_reset_n_o <= 1'b1;
        end else begin
            drive_reset_n_o <= !ctrl[`CTRL_DRV_RESET];
            if (dma_finish) begin
                dma_run <= 1'b0;
                done_flag <= 1'b1;
            end else if (reg_we_i && (reg_addr_i == `OFF_STAT) && reg_wdata_i[`STAT_DONE]) begin
                done_flag <= 1'b0;
            end
            reg_rdata_o <= 32'h0;
            if (reg_re_i) begin
                if (reg_addr_i == `OFF_CTRL) begin
                    reg_rdata_o <= ctrl;
                end else if (reg_addr_i == `OFF_STAT) begin
                    reg_rdata_o <= {{(32-`STAT_WIDTH){1'b0}}, status};
                end else if (reg_addr_i == `OFF_IRQ_EN) begin
                    reg_rdata_o <= {{(32-`STAT_WIDTH){1'b0}}, irq_en};
                end else if (reg_addr_i == `OFF_PIO_TIM) begin
                    reg_rdata_o <= pio_tim;
                end else if (reg_addr_i == `OFF_MDMA_TIM) begin
                    reg_rdata_o <= mdma_tim;
                end else if (reg_addr_i == `OFF_UDMA_TIM) begin
                    reg_rdata_o <= udma_tim;
                end else if (reg_addr_i == `OFF_DMA_BASE) begin
                    reg_rdata_o <= dma_base;
                end else if (reg_addr_i == `OFF_DMA_LEN) begin
                    reg_rdata_o <= dma_len;
                end else if (reg_addr_i == `OFF_CTRL2) begin
                    reg_rdata_o <= ctrl2;
                end else if (reg_addr_i == `OFF_PIN_LVL) begin
                    reg_rdata_o <= {29'h0, pin_f};
                end else if (reg_addr_i == `OFF_BYTE_ORD) begin
                    reg_rdata_o <= {31'h0, byte_ord};
                end else if (reg_addr_i == `OFF_PIO_RESULT || in_window) begin
                    reg_rdata_o <= {16'h0, pio_result};
                end
            end
            if (reg_we_i) begin
                if (reg_addr_i == `OFF_CTRL) begin
                    ctrl <= reg_wdata_i & 32'h1E;
                    if (reg_wdata_i[`CTRL_DMA_START] && !dma_run && if_en) begin
                        dma_run <= 1'b1;
                        dma_out <= reg_wdata_i[`CTRL_DMA_OUT];
                        dma_ultra <= reg_wdata_i[`CTRL_ULTRA];
                        words_left <= dma_len[31:1];
                        crc <= CRC_SEED;
                        crc_pend <= reg_wdata_i[`CTRL_ULTRA] && !reg_wdata_i[`CTRL_DMA_OUT];
                    end
                end else if (reg_addr_i == `OFF_IRQ_EN) begin
                    irq_en <= reg_wdata_i[`STAT_WIDTH-1:0];
                end else if (reg_addr_i == `OFF_PIO_TIM) begin
                    pio_tim <= reg_wdata_i;
                end else if (reg_addr_i == `OFF_MDMA_TIM) begin
                    mdma_tim <= reg_wdata_i;
                end else if (reg_addr_i == `OFF_UDMA_TIM) begin
                    udma_tim <= reg_wdata_i;
                end else if (reg_addr_i == `OFF_DMA_BASE) begin
                    dma_base <= reg_wdata_i;
                end else if (reg_addr_i == `OFF_DMA_LEN) begin
                    dma_len <= reg_wdata_i;
                end else if (reg_addr_i == `OFF_CTRL2) begin
                    ctrl2 <= {31'h0, reg_wdata_i[`CTRL2_INTERFACE_ENABLE_BIT]};
                end else if (reg_addr_i == `OFF_BYTE_ORD) begin
                    byte_ord <= reg_wdata_i[0];
                end
            end
            // One pending task access; more are dropped while busy
            if ((reg_we_i || reg_re_i) && in_window && !pio_pend && if_en) begin
                pio_pend <= 1'b1;
                pio_wr <= reg_we_i;
                pio_idx <= reg_addr_i[5:2];
                pio_wdata <= (reg_addr_i[5:2] == 4'h0) ? reg_wdata_i[15:0] :
                    {8'h00, reg_wdata_i[7:0]};
            end
            case (dstate)
                D_IDLE: begin
                    if (if_en && pio_pend) begin
                        cyc_dma <= 1'b0;
                        cyc_wr <= pio_wr;
                        cnt <= t_pio[`TIM_ACT_LSB+7:`TIM_ACT_LSB];
                        cyc_rec <= t_pio[`TIM_REC_LSB+7:`TIM_REC_LSB];
                        drive_select_lo_n_o <= pio_idx[3];
                        drive_select_hi_n_o <= !pio_idx[3];
                        drive_reg_addr_o <= pio_idx[2:0];
                        drive_data_o <= pio_wdata;
                        drive_data_oe_n_o <= !pio_wr;
                        direction_o <= !pio_wr;
                        dstate <= D_ASSERT;
                    end else if (if_en && (dma_ready || crc_ready)) begin
                        cyc_dma <= 1'b1;
                        cyc_wr <= dma_out || crc_ready;
                        cnt <= t_dma[`TIM_ACT_LSB+7:`TIM_ACT_LSB];
                        cyc_rec <= t_dma[`TIM_REC_LSB+7:`TIM_REC_LSB];
                        dmack_n_o <= 1'b0;
                        drive_data_o <= crc_ready ? crc : swap16(ram_q, byte_ord);
                        drive_data_oe_n_o <= !(dma_out || crc_ready);
                        direction_o <= !(dma_out || crc_ready);
                        dstate <= D_ASSERT;
                    end
                end
                D_ASSERT: begin
                    dior_n_o <= cyc_wr;
                    diow_n_o <= !cyc_wr;
                    dstate <= D_ACTIVE;
                end
                D_ACTIVE: begin
                    if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end else if (cyc_dma || iordy_f) begin
                        dior_n_o <= 1'b1;
                        diow_n_o <= 1'b1;
                        cnt <= cyc_rec;
                        dstate <= D_RECOV;
                        if (!cyc_dma) begin
                            pio_pend <= 1'b0;
                            if (!cyc_wr) begin
                                pio_result <= (pio_idx == 4'h0) ? drive_data_i :
                                    {8'h00, drive_data_i[7:0]};
                            end
                        end else if (crc_pend && words_left == 31'h0) begin
                            crc_pend <= 1'b0;
                        end else begin
                            words_left <= words_left - 31'h1;
                            crc <= crc_step(crc, cyc_wr ? drive_data_o : drive_data_i);
                        end
                    end
                end
                D_RECOV: begin
                    drive_data_oe_n_o <= 1'b1;
                    direction_o <= 1'b1;
                    if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        drive_select_lo_n_o <= 1'b1;
                        drive_select_hi_n_o <= 1'b1;
                        dmack_n_o <= 1'b1;
                        dstate <= D_WAIT;
                    end
                end
                D_WAIT: begin
                    dstate <= D_IDLE;
                end
                default: begin
                    dstate <= D_IDLE;
                end
            endcase
        end
    end
endmodule // ata_host

// [verif/ata_host_assertions.sv]
// Concurrent checks on the drive host port
`timescale 1ns/100ps
`include "ata_host_map.vh"
module ata_host_checker #(
    parameter [31:0] SDRAM_BASE = 32'h0000_0000,
    parameter [31:0] SDRAM_MASK = 32'h00FF_FFFF
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    input wire [31:0] reg_rdata_o,
    input wire irq_o,
    input wire mem_req_o,
    input wire mem_ack_i,
    input wire [31:0] mem_addr_o,
    input wire drive_select_lo_n_o,
    input wire drive_select_hi_n_o,
    input wire dior_n_o,
    input wire diow_n_o,
    input wire dmack_n_o,
    input wire direction_o
);
    reg win_rd;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Task window read data slot
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) win_rd <= 1'b0;
        else win_rd <= reg_re_i && reg_addr_i >= `TASK_WIN_LO && reg_addr_i <= `TASK_WIN_HI;
    end
    sequence mem_waiting;
        mem_req_o && !mem_ack_i;
    endsequence
    sequence mem_held;
        mem_req_o && $stable(mem_addr_o);
    endsequence
    sequence pio_strobe;
        (!dior_n_o || !diow_n_o) && dmack_n_o;
    endsequence
    a_irq_mask_off: assert property (
        reg_we_i && reg_addr_i == `OFF_IRQ_EN && reg_wdata_i[3:0] == 4'h0 |=> !irq_o)
        else $error("irq while masked");
    a_dir_write: assert property (!diow_n_o |-> !direction_o)
        else $error("dir high on write");
    a_dir_read: assert property (!dior_n_o |-> direction_o)
        else $error("dir low on read");
    a_strobe_excl: assert property (dior_n_o || diow_n_o)
        else $error("both strobes low");
    a_select_one: assert property (
        pio_strobe |-> drive_select_lo_n_o != drive_select_hi_n_o)
        else $error("not exactly one chip select");
    a_mem_hold: assert property (mem_waiting |=> mem_held)
        else $error("mem request moved");
    a_mem_sdram: assert property (
        mem_req_o |-> (mem_addr_o & ~SDRAM_MASK) == SDRAM_BASE)
        else $error("address outside SDRAM");
    a_task_width: assert property (win_rd |-> reg_rdata_o[31:16] == 16'h0)
        else $error("task read too wide");
endmodule // ata_host_checker
bind ata_host ata_host_checker #(.SDRAM_BASE(SDRAM_BASE), .SDRAM_MASK(SDRAM_MASK)) i_chk (
    .ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
    .irq_o, .mem_req_o, .mem_ack_i, .mem_addr_o, .drive_select_lo_n_o, .drive_select_hi_n_o,
    .dior_n_o, .diow_n_o, .dmack_n_o, .direction_o);

// [verif/drive_model.sv]
// Behavioural drive: task registers, strobes, DMA words
`timescale 1ns/100ps
module drive_model (
    input wire ref_clk_i,
    input wire slow_i,
    input wire select_lo_n_i,
    input wire [2:0] reg_addr_i,
    input wire rd_n_i,
    input wire wr_n_i,
    input wire dmack_n_i,
    input wire [15:0] data_i,
    output reg [15:0] data_o,
    output wire iordy_o
);
    reg [15:0] task_mem [0:15];
    reg [15:0] last = 16'h0;
    reg [2:0] wait_cnt = 3'h0;
    integer dma_wr = 0, dma_rd = 0;
    wire [3:0] idx = {select_lo_n_i, reg_addr_i};
    assign iordy_o = !slow_i || (rd_n_i && wr_n_i) || wait_cnt == 3'h0;
    always @(posedge ref_clk_i) begin
        if (rd_n_i && wr_n_i) wait_cnt <= 3'h5;
        else if (wait_cnt != 3'h0) wait_cnt <= wait_cnt - 3'h1;
    end
    // Idle bus shows the inverse of the last word
    always @* begin
        if (!rd_n_i && !dmack_n_i) data_o = {8'hC3, dma_rd[7:0]};
        else if (!rd_n_i) data_o = task_mem[idx];
        else data_o = ~last;
    end
    always @(posedge wr_n_i) begin
        last = data_i;
        if (dmack_n_i === 1'b0) dma_wr = dma_wr + 1;
        else task_mem[idx] = data_i;
    end
    always @(posedge rd_n_i) begin
        last = (dmack_n_i === 1'b0) ? {8'hC3, dma_rd[7:0]} : task_mem[idx];
        if (dmack_n_i === 1'b0) dma_rd = dma_rd + 1;
    end
endmodule // drive_model

// [verif/ata_host_tb.sv]
// Self-checking bench for the drive host port
`timescale 1ns/100ps
`include "ata_host_map.vh"
module ata_host_tb;
    reg ref_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [7:0] reg_addr_i = 8'h00;
    reg [31:0] reg_wdata_i = 32'h0;
    reg reg_we_i = 1'b0, reg_re_i = 1'b0, mem_ack_i = 1'b0;
    reg intrq_i = 1'b0, dmarq_i = 1'b0, slow_i = 1'b0;
    reg [15:0] mem_rdata_i = 16'h0, last_rd = 16'h0;
    wire [31:0] reg_rdata_o, mem_addr_o;
    wire [15:0] mem_wdata_o, drive_data_o, drv_q, drive_data_i;
    wire [2:0] drive_reg_addr_o;
    wire irq_o, mem_req_o, mem_we_o, drive_data_oe_n_o, drive_select_lo_n_o;
    wire drive_select_hi_n_o, dior_n_o, diow_n_o, dmack_n_o, direction_o;
    wire drive_reset_n_o, iordy_i;
    reg [31:0] base = 32'h0, rnd, v, d, t, s;
    reg [7:0] k;
    integer err_count = 0, samples_checked = 0, mem_n = 0, rd0 = 0, dsum;
    assign drive_data_i = drive_data_oe_n_o ? drv_q : drive_data_o;
    always #50 ref_clk_i = ~ref_clk_i;
    ata_host i_dut (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
        .reg_rdata_o, .irq_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i,
        .mem_ack_i, .drive_data_i, .drive_data_o, .drive_data_oe_n_o, .drive_select_lo_n_o,
        .drive_select_hi_n_o, .drive_reg_addr_o, .dior_n_o, .diow_n_o, .dmack_n_o,
        .direction_o, .drive_reset_n_o, .iordy_i, .intrq_i, .dmarq_i);
    drive_model i_drv (.ref_clk_i, .slow_i, .select_lo_n_i(drive_select_lo_n_o),
        .reg_addr_i(drive_reg_addr_o), .rd_n_i(dior_n_o), .wr_n_i(diow_n_o),
        .dmack_n_i(dmack_n_o), .data_i(drive_data_i), .data_o(drv_q), .iordy_o(iordy_i));
    task check(input string name, input [31:0] exp, input [31:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] x);
        begin
            reg_addr_i <= a;
            reg_wdata_i <= x;
            reg_we_i <= 1'b1;
            @(posedge ref_clk_i);
            reg_we_i <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask
    task rd(input [7:0] a, output [31:0] x);
        begin
            reg_addr_i <= a;
            reg_re_i <= 1'b1;
            @(posedge ref_clk_i);
            reg_re_i <= 1'b0;
            #1 x = reg_rdata_o;
            @(posedge ref_clk_i);
        end
    endtask
    task wait_stat(input integer b, input reg x);
        integer n;
        reg [31:0] st;
        begin
            n = 0;
            st = {32{~x}};
            while (st[b] !== x && n < 300) begin
                rd(`OFF_STAT, st);
                n = n + 1;
            end
            check("status wait", x, st[b]);
        end
    endtask
    // Memory partner with random stalls
    always @(posedge ref_clk_i) begin
        rnd = $urandom;
        if (mem_req_o && mem_ack_i) begin
            check("mem addr", (base + 2 * mem_n) & 32'h00FF_FFFF, mem_addr_o);
            dsum = rd0 + mem_n;
            if (mem_we_o) check("mem data", {8'hC3, dsum[7:0]}, mem_wdata_o);
            else last_rd = mem_rdata_i;
            mem_n = mem_n + 1;
        end
        mem_ack_i <= mem_req_o && !mem_ack_i && rnd[17:16] != 2'b00;
        mem_rdata_i <= rnd[15:0];
    end
    task dma(input [31:0] c);
        integer w0;
        begin
            base = $urandom & 32'h00FF_FFFE;
            mem_n = 0;
            w0 = i_drv.dma_wr;
            rd0 = i_drv.dma_rd;
            wr(`OFF_DMA_BASE, base);
            wr(`OFF_DMA_LEN, 32'h8);
            wr(`OFF_CTRL, c);
            dmarq_i <= 1'b1;
            wait_stat(`STAT_DONE, 1'b1);
            repeat (20) @(posedge ref_clk_i);
            dmarq_i <= 1'b0;
            check("memory words", 4, mem_n);
            check("drive writes", c[1] ? 4 : c[2], i_drv.dma_wr - w0);
            check("drive reads", c[1] ? 0 : 4, i_drv.dma_rd - rd0);
            rd(`OFF_DMA_BASE, v);
            check("base kept", base, v);
            rd(`OFF_DMA_LEN, v);
            check("length kept", 32'h8, v);
            wr(`OFF_STAT, 32'h1);
            rd(`OFF_STAT, v);
            check("done cleared", 32'h0, v[`STAT_DONE]);
            if (c[1]) check("last word", last_rd, i_drv.last);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        err_count = err_count + 1;
        stop_test;
    end
    initial begin
        s = $urandom(32'hD045F01F);
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        rd(8'h30, v);
        check("unmapped", 32'h0, v);
        rd(`OFF_PIO_TIM, v);
        check("timing reset", `TIM_RST, v);
        wr(`OFF_CTRL2, 32'h1);
        for (k = 8'h00; k < 8'h03; k = k + 8'h01) begin
            t = $urandom & 32'h0303_0303;
            wr(`OFF_PIO_TIM + 8'h04 * k, t);
            rd(`OFF_PIO_TIM + 8'h04 * k, v);
            check("timing", t, v);
        end
        // Task registers, master and slave sets in turn
        for (k = 8'h00; k < 8'h10; k = k + 8'h01) begin
            d = $urandom;
            slow_i <= d[31];
            wr(`OFF_CTRL, {28'h0, k[0], 3'h0});
            wr(`TASK_WIN_LO + 8'h04 * k, d);
            wait_stat(`STAT_PIO_BUSY, 1'b0);
            rd(`TASK_WIN_LO + 8'h04 * k, v);
            wait_stat(`STAT_PIO_BUSY, 1'b0);
            rd(`OFF_PIO_RESULT, v);
            check("pio read", k == 8'h00 ? {16'h0, d[15:0]} : {24'h0, d[7:0]}, v);
        end
        intrq_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        rd(`OFF_STAT, v);
        check("intrq level", 32'h1, v[`STAT_INTRQ]);
        wr(`OFF_IRQ_EN, 32'h2);
        #1 check("irq on", 32'h1, irq_o);
        repeat (20) @(posedge ref_clk_i);
        #1 check("irq held", 32'h1, irq_o);
        wr(`OFF_IRQ_EN, 32'h0);
        #1 check("irq masked", 32'h0, irq_o);
        intrq_i <= 1'b0;
        // Both DMA kinds, both directions
        for (k = 8'h00; k < 8'h04; k = k + 8'h01) dma({29'h0, k[1:0], 1'b1});
        stop_test;
    end
endmodule // ata_host_tb
